// file: verilog/gpio_port_pin_control.sv
// Operation
// - After reset all pins except debug pins are floating inputs with both pulls off.
// - Debug pins come up pulled: 15 up, 14 down, 13 up, B4 up.
// - Input level register samples every pin each clock, in every mode except analog input.
// - Pulled/floating input: driver off, trigger on, pull per configuration.
// - Analog input: driver, digital path and pulls off, reads zero.
// - General output: driver on, sampling on, pulls off.
// - Push-pull drives the latch value; latch reads back as written.
// - Open-drain: latch 0 drives low, 1 releases; read pin via input.
// - Alternate function: peripheral drives pin, pulls off, still sampled.
// - Set/clear register changes latch bits in one write.
// - Locked pin configuration ignores writes until reset.
// - Mode field: 00 input, 01 10MHz, 10 2MHz, 11 50MHz.
// - Input function: 00 analog, 01 floating, 10 pulled, 11 reserved.
// - Output function: latch/peripheral driven, push-pull/open-drain.
// - Low configuration register at 0x00 resets to 0x44444444.
// - High configuration register at 0x04 holds pins 8 to 15.
// - Upper half clears, lower half sets; set wins on both.
// - Clear-only register low bits clear latch bits on one.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_control #(
  parameter int           PINS        = 16,
  parameter logic [15:0]  DEBUG_PULLS = 16'h0000,
  parameter logic [15:0]  DEBUG_LATCH = 16'h0000
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire gpio_port_pkg::reg_req_t req,
  output logic [31:0]                 rdata,
  input  wire logic [PINS-1:0]        pin_in,
  output logic [PINS-1:0]             pin_out,
  output logic [PINS-1:0]             pin_oe,
  output logic [PINS-1:0]             pull_up,
  output logic [PINS-1:0]             pull_down,
  output logic [PINS-1:0]             analog_sel,
  input  wire logic [PINS-1:0]        periph_out,
  output logic [2*PINS-1:0]           pin_speed
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [63:0]        config_bits;
  logic [PINS-1:0]    out_latch;
  logic [PINS-1:0]    in_level;
  logic [PINS-1:0]    locked;
  logic [PINS-1:0]    lock_pending;
  logic               lock_key;
  gpio_port_pkg::lock_state_t lock_state;
  gpio_port_pkg::lock_state_t next_lock_state;
  logic [PINS-1:0]    sample_en;
  logic [63:0]        cfg_wmask;
  logic [63:0]        reset_cfg;
  logic [PINS-1:0]    next_latch;
  logic [31:0]        next_rdata;

  logic wr_low;
  logic wr_high;
  logic wr_out;
  logic wr_setclr;
  logic wr_clr;
  logic wr_lock;

  assign wr_low    = req.wr && (req.addr == gpio_port_pkg::OFS_CFG_LOW);
  assign wr_high   = req.wr && (req.addr == gpio_port_pkg::OFS_CFG_HIGH);
  assign wr_out    = req.wr && (req.addr == gpio_port_pkg::OFS_OUT_LATCH);
  assign wr_setclr = req.wr && (req.addr == gpio_port_pkg::OFS_SET_CLR);
  assign wr_clr    = req.wr && (req.addr == gpio_port_pkg::OFS_CLR_ONLY);
  assign wr_lock   = req.wr && (req.addr == gpio_port_pkg::OFS_LOCK);

  // ------------------------------------------------------------
  // Reset configuration with debug pins pulled
  // ------------------------------------------------------------
  always_comb begin
    reset_cfg = {2{gpio_port_pkg::CFG_RESET}};
    for (int i = 0; i < PINS; i++) begin
      if (DEBUG_PULLS[i]) begin
        reset_cfg[i*gpio_port_pkg::CFG_BITS +: gpio_port_pkg::CFG_BITS] =
          gpio_port_pkg::CFG_PULLED_IN;
      end
    end
  end

  // Locked pins keep their four configuration bits
  always_comb begin
    cfg_wmask = '1;
    for (int i = 0; i < PINS; i++) begin
      if (locked[i]) begin
        cfg_wmask[i*gpio_port_pkg::CFG_BITS +: gpio_port_pkg::CFG_BITS] =
          4'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Reset loads the strap pattern; debug pins come up pulled, the rest
  // float. The pull direction of a debug pin comes from its latch bit.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      config_bits <= reset_cfg;
    end else begin
      if (wr_low) begin
        config_bits[31:0] <= (config_bits[31:0] & ~cfg_wmask[31:0])
                           | (req.wdata & cfg_wmask[31:0]);
      end
      if (wr_high) begin
        config_bits[63:32] <= (config_bits[63:32] & ~cfg_wmask[63:32])
                            | (req.wdata & cfg_wmask[63:32]);
      end
    end
  end

  // ------------------------------------------------------------
  // Output latch
  // ------------------------------------------------------------
  always_comb begin
    next_latch = out_latch;
    if (wr_out) begin
      next_latch = req.wdata[PINS-1:0];
    end else if (wr_setclr) begin
      next_latch = (out_latch
                   & ~req.wdata[gpio_port_pkg::CLR_HALF_LSB +: PINS])
                   | req.wdata[PINS-1:0];
    end else if (wr_clr) begin
      next_latch = out_latch & ~req.wdata[PINS-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // Latch bits of debug pins pick pull-up or pull-down
      out_latch <= gpio_port_pkg::OUT_RESET | DEBUG_LATCH;
    end else begin
      out_latch <= next_latch;
    end
  end

  // ------------------------------------------------------------
  // Input sampling, every clock
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      in_level <= '0;
    end else begin
      in_level <= pin_in & sample_en;
    end
  end

  // ------------------------------------------------------------
  // Lock key sequencer: key 1, key 0, key 1, then a read-back
  // ------------------------------------------------------------
  assign lock_key = req.wdata[gpio_port_pkg::LOCK_KEY_BIT];

  always_comb begin
    next_lock_state = lock_state;
    if (wr_lock) begin
      next_lock_state = gpio_port_pkg::LK_IDLE;
      case (lock_state)
        gpio_port_pkg::LK_IDLE: begin
          if (lock_key) next_lock_state = gpio_port_pkg::LK_ONE;
        end
        gpio_port_pkg::LK_ONE: begin
          if (!lock_key) next_lock_state = gpio_port_pkg::LK_ZERO;
        end
        gpio_port_pkg::LK_ZERO: begin
          if (lock_key) next_lock_state = gpio_port_pkg::LK_CHECK;
        end
        default: begin
          if (lock_key) next_lock_state = gpio_port_pkg::LK_ONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lock_state <= gpio_port_pkg::LK_IDLE;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // Pin mask of the latest key write; the closing write must repeat it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lock_pending <= '0;
    end else if (wr_lock && lock_state != gpio_port_pkg::LK_ZERO) begin
      lock_pending <= req.wdata[PINS-1:0];
    end
  end

  // Only the pattern captured on the second key write may commit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      locked <= '0;
    end else if (wr_lock && lock_state == gpio_port_pkg::LK_ZERO && lock_key
                 && req.wdata[PINS-1:0] == lock_pending) begin
      locked <= locked | lock_pending;
    end
  end

  // ------------------------------------------------------------
  // Per-pin drive logic
  // ------------------------------------------------------------
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    gpio_pin_cell u_cell (
      .cfg        (config_bits[p*gpio_port_pkg::CFG_BITS +:
                               gpio_port_pkg::CFG_BITS]),
      .latch      (out_latch[p]),
      .periph_out (periph_out[p]),
      .pin_in     (pin_in[p]),
      .pin_out    (pin_out[p]),
      .pin_oe     (pin_oe[p]),
      .pull_up    (pull_up[p]),
      .pull_down  (pull_down[p]),
      .sample_en  (sample_en[p]),
      .analog_sel (analog_sel[p])
    );
    assign pin_speed[2*p +: 2] =
      config_bits[p*gpio_port_pkg::CFG_BITS +: 2];
  end

  // ------------------------------------------------------------
  // Read data select; reserved and write-only words read zero
  // ------------------------------------------------------------
  // Set/clear and clear-only words return zero, so software never
  // mistakes a strobe word for latch state.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (req.addr == gpio_port_pkg::OFS_CFG_LOW) begin
      next_rdata = config_bits[31:0];
    end else if (req.addr == gpio_port_pkg::OFS_CFG_HIGH) begin
      next_rdata = config_bits[63:32];
    end else if (req.addr == gpio_port_pkg::OFS_IN_LEVEL) begin
      next_rdata = {16'h0000, in_level};
    end else if (req.addr == gpio_port_pkg::OFS_OUT_LATCH) begin
      next_rdata = {16'h0000, out_latch};
    end else if (req.addr == gpio_port_pkg::OFS_LOCK) begin
      next_rdata = {15'h0000, (lock_state == gpio_port_pkg::LK_CHECK),
                    locked};
    end
  end

  // ------------------------------------------------------------
  // Read data register
  // ------------------------------------------------------------
  // Holds between reads so a slow master may sample it late
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end
  end

endmodule : gpio_port_pin_control
`default_nettype wire

// file: verilog/gpio_port_pkg.sv
package gpio_port_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_CFG_LOW   = 5'h00;
  localparam logic [4:0] OFS_CFG_HIGH  = 5'h04;
  localparam logic [4:0] OFS_IN_LEVEL  = 5'h08;
  localparam logic [4:0] OFS_OUT_LATCH = 5'h0C;
  localparam logic [4:0] OFS_SET_CLR   = 5'h10;
  localparam logic [4:0] OFS_CLR_ONLY  = 5'h14;
  localparam logic [4:0] OFS_LOCK      = 5'h18;

  // ------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------
  localparam int NUM_PINS       = 16;
  localparam int PINS_PER_CFG   = 8;
  localparam int CFG_BITS       = 4;
  localparam int MODE_LSB       = 0;
  localparam int FUNC_LSB       = 2;
  localparam int CLR_HALF_LSB   = 16;
  localparam int LOCK_KEY_BIT   = 16;
  localparam logic [31:0] CFG_RESET      = 32'h4444_4444;
  localparam logic [15:0] OUT_RESET      = 16'h0000;
  localparam logic [3:0]  CFG_PULLED_IN  = 4'h8;
  localparam logic [3:0]  CFG_FLOAT_IN   = 4'h4;

  // Mode field codes
  localparam logic [1:0] MODE_INPUT  = 2'h0;
  localparam logic [1:0] MODE_OUT_10 = 2'h1;
  localparam logic [1:0] MODE_OUT_2  = 2'h2;
  localparam logic [1:0] MODE_OUT_50 = 2'h3;

  // Function field codes, input mode
  localparam logic [1:0] FN_ANALOG   = 2'h0;
  localparam logic [1:0] FN_FLOATING = 2'h1;
  localparam logic [1:0] FN_PULLED   = 2'h2;

  // Function field bits, output mode
  localparam int FN_OPEN_DRAIN_BIT = 0;
  localparam int FN_PERIPH_BIT     = 1;

  // ------------------------------------------------------------
  // Register bus carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Lock key sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    LK_IDLE  = 2'b00,
    LK_ONE   = 2'b01,
    LK_ZERO  = 2'b11,
    LK_CHECK = 2'b10
  } lock_state_t;

endpackage : gpio_port_pkg

// file: verilog/gpio_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell (
  input  wire logic [3:0] cfg,
  input  wire logic       latch,
  input  wire logic       periph_out,
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            pull_up,
  output logic            pull_down,
  output logic            sample_en,
  output logic            analog_sel
);

  logic [1:0] mode;
  logic [1:0] func;
  logic       drive_val;
  logic       is_output;

  assign mode      = cfg[gpio_port_pkg::MODE_LSB +: 2];
  assign func      = cfg[gpio_port_pkg::FUNC_LSB +: 2];
  assign is_output = (mode != gpio_port_pkg::MODE_INPUT);

  always_comb begin
    drive_val  = func[gpio_port_pkg::FN_PERIPH_BIT] ? periph_out : latch;
    pin_out    = 1'b0;
    pin_oe     = 1'b0;
    pull_up    = 1'b0;
    pull_down  = 1'b0;
    sample_en  = 1'b1;
    analog_sel = 1'b0;
    if (is_output) begin
      // Pulls stay off while driving
      if (func[gpio_port_pkg::FN_OPEN_DRAIN_BIT]) begin
        pin_out = 1'b0;
        pin_oe  = ~drive_val;
      end else begin
        pin_out = drive_val;
        pin_oe  = 1'b1;
      end
    end else begin
      case (func)
        gpio_port_pkg::FN_ANALOG: begin
          sample_en  = 1'b0;
          analog_sel = 1'b1;
        end
        gpio_port_pkg::FN_PULLED: begin
          pull_up   = latch;
          pull_down = ~latch;
        end
        default: begin
          // Floating, and reserved code treated as floating
        end
      endcase
    end
  end

  // Sampling of pin_in is done in the port register; unused here
  logic unused_in;
  assign unused_in = pin_in;

endmodule : gpio_pin_cell
`default_nettype wire

// file: dv/gpio_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_monitor #(
  parameter int PINS = 16
) (
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  input wire gpio_port_pkg::reg_req_t req,
  input wire logic [31:0]             rdata,
  input wire logic [PINS-1:0]         pin_in,
  input wire logic [PINS-1:0]         pin_oe,
  input wire logic [PINS-1:0]         pull_up,
  input wire logic [PINS-1:0]         pull_down,
  input wire logic [PINS-1:0]         analog_sel,
  input wire logic [2*PINS-1:0]       pin_speed
);
  // ----------------------------------------
  // Pin properties
  // ----------------------------------------
  logic [PINS-1:0] in_mode;
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      in_mode[p] = (pin_speed[2*p +: 2] == 2'h0);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  reset_float_a: assert property ($fell(sys_rst) |->
    pin_oe == '0 && pull_up == '0 && pull_down == '0 && pin_speed == '0)
    else $error("pins not floating after reset");
  input_undriven_a: assert property ((pin_oe & in_mode) == '0)
    else $error("driver on in input mode");
  output_nopull_a: assert property (((pull_up | pull_down) & ~in_mode) == '0)
    else $error("pull on in output mode");
  pull_exclusive_a: assert property ((pull_up & pull_down) == '0)
    else $error("both pulls on");
  analog_quiet_a: assert property ((analog_sel &
    (pin_oe | pull_up | pull_down | ~in_mode)) == '0)
    else $error("analog pin not quiet");
  input_read_a: assert property (($stable(pin_in) && $stable(analog_sel))[*4]
    ##0 (req.rd && req.addr == gpio_port_pkg::OFS_IN_LEVEL)
    |=> rdata == {16'h0, $past(pin_in) & ~$past(analog_sel)})
    else $error("input level read wrong");
  latch_readback_a: assert property ((req.wr && req.addr == 5'h0C)
    ##1 (req.rd && req.addr == 5'h0C)
    |=> rdata == {16'h0, $past(req.wdata[15:0], 2)})
    else $error("latch readback wrong");
  set_clear_a: assert property ((req.wr && req.addr == 5'h10)
    ##1 (req.rd && req.addr == 5'h0C) |=>
    (rdata[15:0] & $past(req.wdata[15:0], 2)) == $past(req.wdata[15:0], 2)
    && (rdata[15:0] & $past(req.wdata[31:16] & ~req.wdata[15:0], 2)) == 0)
    else $error("set or clear lost");
  clear_only_a: assert property ((req.wr && req.addr == 5'h14)
    ##1 (req.rd && req.addr == 5'h0C)
    |=> (rdata[15:0] & $past(req.wdata[15:0], 2)) == 16'h0)
    else $error("clear lost");
endmodule : gpio_port_monitor
`default_nettype wire

// file: dv/gpio_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_partner #(
  parameter int PINS = 16
) (
  input  wire logic            mclk,
  input  wire logic [PINS-1:0] pin_out,
  input  wire logic [PINS-1:0] pin_oe,
  input  wire logic [PINS-1:0] pull_up,
  input  wire logic [PINS-1:0] pull_down,
  input  wire logic [PINS-1:0] ext_en,
  input  wire logic [PINS-1:0] ext_val,
  output logic      [PINS-1:0] pin_in
);
  // ----------------------------------------
  // Pad level
  // ----------------------------------------
  // Undriven floating pins wander so stale values never match
  logic [PINS-1:0] drift = '0;
  always_ff @(posedge mclk) begin
    drift <= ~drift;
  end
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      if (pin_oe[p]) pin_in[p] = pin_out[p];
      else if (ext_en[p]) pin_in[p] = ext_val[p];
      else if (pull_up[p]) pin_in[p] = 1'b1;
      else if (pull_down[p]) pin_in[p] = 1'b0;
      else pin_in[p] = drift[p];
    end
  end
endmodule : gpio_pin_partner
`default_nettype wire

// file: dv/gpio_port_pin_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_control_bench;
  logic                    mclk, sys_rst, rd_seen;
  gpio_port_pkg::reg_req_t req;
  logic [31:0]             rdata, pin_speed, w, expq[$];
  logic [15:0]             pin_in, pin_out, pin_oe, pull_up, pull_down;
  logic [15:0]             analog_sel, periph_out, ext_en, ext_val;
  logic [15:0]             lat, d, e;
  logic [3:0]              nb;
  int                      miscompares, num_checks, seed;

  gpio_port_pin_control dut (.mclk(mclk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up(pull_up), .pull_down(pull_down), .analog_sel(analog_sel),
    .periph_out(periph_out), .pin_speed(pin_speed));
  gpio_pin_partner pads (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up(pull_up), .pull_down(pull_down), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------
  // Bus tasks and checking
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(negedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] v);
    @(negedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    expq.push_back(v);
  endtask : rd
  task automatic idle(input int n);
    @(negedge mclk);
    req <= '0;
    repeat (n) @(negedge mclk);
  endtask : idle
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge mclk) rd_seen <= req.rd && !sys_rst;
  always @(negedge mclk) begin
    if (rd_seen) chk(rdata, expq.pop_front());
  end
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end

  initial begin
    seed = 61; sys_rst = 1'b1; req = '0;
    ext_en = '1; ext_val = '0; periph_out = '0;
    miscompares = 0; num_checks = 0;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    d = 16'($random(seed));
    ext_val = d;
    idle(4);
    rd(gpio_port_pkg::OFS_CFG_LOW, 32'h4444_4444);
    rd(gpio_port_pkg::OFS_CFG_HIGH, 32'h4444_4444);
    rd(gpio_port_pkg::OFS_OUT_LATCH, 32'h0);
    rd(5'h1C, 32'h0);
    rd(gpio_port_pkg::OFS_IN_LEVEL, {16'h0, d});
    // Pulled inputs follow the latch
    lat = 16'($random(seed));
    ext_en = '0;
    wr(gpio_port_pkg::OFS_CFG_LOW, 32'h8888_8888);
    wr(gpio_port_pkg::OFS_CFG_HIGH, 32'h8888_8888);
    wr(gpio_port_pkg::OFS_OUT_LATCH, {16'h0, lat});
    rd(gpio_port_pkg::OFS_OUT_LATCH, {16'h0, lat});
    idle(4);
    rd(gpio_port_pkg::OFS_IN_LEVEL, {16'h0, lat});
    w = $random(seed);
    wr(gpio_port_pkg::OFS_SET_CLR, w);
    rd(gpio_port_pkg::OFS_OUT_LATCH, {16'h0, lat & ~w[31:16] | w[15:0]});
    wr(gpio_port_pkg::OFS_SET_CLR, 32'hFFFF_00FF);
    rd(gpio_port_pkg::OFS_OUT_LATCH, 32'h0000_00FF);
    w = $random(seed);
    wr(gpio_port_pkg::OFS_CLR_ONLY, w);
    rd(gpio_port_pkg::OFS_OUT_LATCH, {16'h0, 16'h00FF & ~w[15:0]});
    // Analog input reads zero
    ext_en = '1;
    ext_val = '1;
    wr(gpio_port_pkg::OFS_CFG_LOW, 32'h0);
    wr(gpio_port_pkg::OFS_CFG_HIGH, 32'h0);
    idle(4);
    rd(gpio_port_pkg::OFS_IN_LEVEL, 32'h0);
    for (int n = 0; n < 16; n++) begin
      nb = 4'(n);
      if (nb[1:0] == 2'h0) continue;
      d = 16'($random(seed));
      e = 16'($random(seed));
      periph_out = 16'($random(seed));
      ext_val = e;
      wr(gpio_port_pkg::OFS_CFG_LOW, {8{nb}});
      wr(gpio_port_pkg::OFS_CFG_HIGH, {8{nb}});
      wr(gpio_port_pkg::OFS_OUT_LATCH, {16'h0, d});
      idle(4);
      chk(pin_speed, {16{nb[1:0]}});
      lat = nb[3] ? periph_out : d;
      rd(gpio_port_pkg::OFS_IN_LEVEL, {16'h0, nb[2] ? lat & e : lat});
      rd(gpio_port_pkg::OFS_OUT_LATCH, {16'h0, d});
    end
    // Broken key then good key on pins 0 and 1
    wr(gpio_port_pkg::OFS_LOCK, 32'h0001_0004);
    wr(gpio_port_pkg::OFS_LOCK, 32'h0001_0004);
    wr(gpio_port_pkg::OFS_LOCK, 32'h0001_0003);
    wr(gpio_port_pkg::OFS_LOCK, 32'h0000_0003);
    wr(gpio_port_pkg::OFS_LOCK, 32'h0001_0003);
    wr(gpio_port_pkg::OFS_CFG_LOW, 32'h1111_1111);
    rd(gpio_port_pkg::OFS_CFG_LOW, 32'h1111_11FF);
    rd(gpio_port_pkg::OFS_LOCK, 32'h0001_0003);
    idle(1);
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    wr(gpio_port_pkg::OFS_CFG_LOW, 32'h1111_1111);
    rd(gpio_port_pkg::OFS_CFG_LOW, 32'h1111_1111);
    idle(4);
    stop_test();
  end
endmodule : gpio_port_pin_control_bench

bind gpio_port_pin_control gpio_port_monitor #(.PINS(PINS)) mon (
  .mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
  .pin_in(pin_in), .pin_oe(pin_oe), .pull_up(pull_up),
  .pull_down(pull_down), .analog_sel(analog_sel), .pin_speed(pin_speed));
`default_nettype wire
